// ==== core/lgb_logic_lib.sv ====
// top of the logic gate and timing element library
`include "lgb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lgb_logic_lib #(
  parameter int unsigned BASE_CYC = `LGB_TB_10MS_CYC
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic [3:0]             i_gate_in,
  input  wire logic [1:0]             i_xor_in,
  input  wire logic [3:0]             i_expr_in,
  input  wire logic [2:0]             i_expr_op,
  input  wire logic [3:0]             i_expr_neg,
  input  wire logic                   i_latch_set,
  input  wire logic                   i_latch_clr,
  input  wire logic                   i_latch_set_wins,
  input  wire logic                   i_pulse_in,
  input  wire logic [1:0]             i_pulse_edge,
  input  wire logic                   i_toggle_in,
  input  wire logic [1:0]             i_tb_sel,
  input  wire logic                   i_dly_in,
  input  wire logic [`LGB_TIME_W-1:0] i_dly_on_time,
  input  wire logic [`LGB_TIME_W-1:0] i_dly_off_time,
  input  wire logic                   i_os_in,
  input  wire logic                   i_os_retrig,
  input  wire logic [`LGB_TIME_W-1:0] i_os_time,
  input  wire logic                   i_flash_en,
  input  wire logic [`LGB_TIME_W-1:0] i_flash_time,
  input  wire logic [`LGB_TOD_W-1:0]  i_tod,
  input  wire logic [`LGB_TOD_W-1:0]  i_sched_on,
  input  wire logic [`LGB_TOD_W-1:0]  i_sched_off,
  input  wire logic                   i_cnt_in,
  input  wire logic                   i_cnt_clr,
  input  wire logic [`LGB_CNT_W-1:0]  i_cnt_set,
  output logic                        o_and4,
  output logic                        o_or4,
  output logic                        o_not,
  output logic                        o_xor2,
  output logic                        o_nand4,
  output logic                        o_nor4,
  output logic                        o_expr,
  output logic                        o_latch,
  output logic                        o_pulse,
  output logic                        o_toggle,
  output logic                        o_dly,
  output logic                        o_os,
  output logic                        o_flash,
  output logic                        o_sched,
  output logic                        o_cnt_hit,
  output logic [`LGB_CNT_W-1:0]       o_cnt_value
);
  // the tick divider is 20 bits wide, which caps the cycles per tick
  if (BASE_CYC < 1 || BASE_CYC > 1000000) begin : g_bad_base
    $error("BASE_CYC out of range");
  end
  // pins cross from outside: two-flop synchronisers on every bit input except the pulse edge and timebase selects;
  // timing and schedule words are not synchronised, so they may only
  // change while the element that reads them is idle
  localparam int NSYNC = 28;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  assign raw = {
    i_gate_in,
    i_xor_in,
    i_expr_in,
    i_latch_set,
    i_latch_clr,
    i_pulse_in,
    i_toggle_in,
    i_dly_in,
    i_os_in,
    i_flash_en,
    i_cnt_in,
    i_cnt_clr,
    i_expr_neg,
    i_expr_op,
    i_os_retrig,
    i_latch_set_wins
  };
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic [3:0] g_in;
  logic [1:0] x_in;
  logic [3:0] e_in;
  logic       l_set;
  logic       l_clr;
  logic       p_in;
  logic       t_in;
  logic       d_in;
  logic       os_in;
  logic       f_en;
  logic       c_in;
  logic       c_clr;
  logic [3:0] e_neg;
  logic [2:0] e_op;
  logic       os_rt;
  logic       l_sw;
  // unpack in the same order as raw above
  assign {
    g_in,
    x_in,
    e_in,
    l_set,
    l_clr,
    p_in,
    t_in,
    d_in,
    os_in,
    f_en,
    c_in,
    c_clr,
    e_neg,
    e_op,
    os_rt,
    l_sw
  } = s2;

  lgb_tick_if tk ();
  lgb_tick_gen #(
    .BASE_CYC (BASE_CYC)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .tk        (tk)
  );
  logic dly_w;
  logic os_w;
  lgb_timer u_timer (
    .i_sys_clk      (i_sys_clk),
    .i_sys_rst      (i_sys_rst),
    .tk             (tk),
    .i_tb_sel       (i_tb_sel),
    .i_dly_in       (d_in),
    .i_dly_on_time  (i_dly_on_time),
    .i_dly_off_time (i_dly_off_time),
    .i_os_in        (os_in),
    .i_os_retrig    (os_rt),
    .i_os_time      (i_os_time),
    .o_dly_out      (dly_w),
    .o_os_out       (os_w)
  );
  // same timebase select as the timers, so the flasher steps with them
  logic tick;
  always_comb begin
    case (i_tb_sel)
      `LGB_TB_10MS:  tick = tk.tick_10ms;
      `LGB_TB_100MS: tick = tk.tick_100ms;
      `LGB_TB_1S:    tick = tk.tick_1s;
      default:       tick = tk.tick_10ms;
    endcase
  end

  typedef struct packed {
    logic                   and4;
    logic                   or4;
    logic                   inv;
    logic                   xor2;
    logic                   nand4;
    logic                   nor4;
    logic                   expr;
    logic                   latch;
    logic                   p_d;
    logic                   pulse;
    logic                   t_d;
    logic                   toggle;
    logic                   dly;
    logic                   os;
    logic [`LGB_TIME_W-1:0] fcnt;
    logic                   flash;
    logic                   sched;
    logic                   c_d;
    logic [`LGB_CNT_W-1:0]  cval;
    logic                   chit;
  } lgb_top_st_t;
  lgb_top_st_t q;
  lgb_top_st_t next_q;

  logic [3:0] e_term;
  logic       e_val;
  logic       rise;
  logic       fall;
  logic       tgl_rise;
  logic       c_event;
  logic [`LGB_CNT_W-1:0] c_next;

  // per-input negation ahead of the selected operator
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_neg
      assign e_term[gi] = e_in[gi] ^ e_neg[gi];
    end
  endgenerate

  always_comb begin
    case (lgb_pkg::lgb_op_t'(e_op))
      lgb_pkg::LGB_OP_AND:  e_val = &e_term;
      lgb_pkg::LGB_OP_OR:   e_val = |e_term;
      lgb_pkg::LGB_OP_NOR:  e_val = ~|e_term;
      lgb_pkg::LGB_OP_XOR:  e_val = ^e_term;
      lgb_pkg::LGB_OP_NAND: e_val = ~&e_term;
      default:              e_val = 1'b0;
    endcase
  end

  // edge memories reset low, the idle level of the pins, so no false
  // edge follows the release of reset
  assign rise     = p_in & ~q.p_d;
  assign fall     = ~p_in & q.p_d;
  assign tgl_rise = t_in & ~q.t_d;
  assign c_event  = c_in & ~q.c_d;
  assign c_next   = q.cval + `LGB_CNT_W'(1);

  always_comb begin
    next_q       = q;
    next_q.and4  = &g_in;
    next_q.or4   = |g_in;
    next_q.inv   = ~g_in[0];
    next_q.xor2  = x_in[0] ^ x_in[1];
    next_q.nand4 = ~&g_in;
    next_q.nor4  = ~|g_in;
    next_q.expr  = e_val;
    // latch: reset wins unless set priority is selected
    if (l_set && l_clr) begin
      next_q.latch = l_sw;
    end else if (l_set) begin
      next_q.latch = 1'b1;
    end else if (l_clr) begin
      next_q.latch = 1'b0;
    end
    next_q.p_d = p_in;
    // edge choice is static configuration, read without a synchroniser
    case (lgb_pkg::lgb_edge_t'(i_pulse_edge))
      lgb_pkg::LGB_EDGE_FALL: next_q.pulse = fall;
      lgb_pkg::LGB_EDGE_RISE: next_q.pulse = rise;
      lgb_pkg::LGB_EDGE_BOTH: next_q.pulse = rise | fall;
      default:                next_q.pulse = 1'b0;
    endcase
    next_q.t_d = t_in;
    if (tgl_rise) begin
      next_q.toggle = ~q.toggle;
    end
    // timer results pass one more flop so every top output is registered
    next_q.dly = dly_w;
    next_q.os  = os_w;
    // flasher: half period equals the flash time, zero time holds low
    if (!f_en || i_flash_time == '0) begin
      next_q.fcnt  = '0;
      next_q.flash = 1'b0;
    end else if (tick) begin
      if (q.fcnt + 1'b1 >= i_flash_time) begin
        next_q.fcnt  = '0;
        next_q.flash = ~q.flash;
      end else begin
        next_q.fcnt = q.fcnt + 1'b1;
      end
    end
    // schedule window may wrap past midnight
    if (i_sched_on <= i_sched_off) begin
      next_q.sched = (i_tod >= i_sched_on) && (i_tod < i_sched_off);
    end else begin
      next_q.sched = (i_tod >= i_sched_on) || (i_tod < i_sched_off);
    end
    next_q.c_d = c_in;
    // clear beats a counting event in the same cycle; counter saturates
    if (c_clr) begin
      next_q.cval = '0;
    end else if (c_event && q.cval != '1) begin
      next_q.cval = c_next;
    end
    // hit follows the new value, so it rises together with the count
    next_q.chit = !c_clr && (next_q.cval >= i_cnt_set);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) q <= '0;
    else           q <= next_q;
  end

  assign o_and4      = q.and4;
  assign o_or4       = q.or4;
  assign o_not       = q.inv;
  assign o_xor2      = q.xor2;
  assign o_nand4     = q.nand4;
  assign o_nor4      = q.nor4;
  assign o_expr      = q.expr;
  assign o_latch     = q.latch;
  assign o_pulse     = q.pulse;
  assign o_toggle    = q.toggle;
  assign o_dly       = q.dly;
  assign o_os        = q.os;
  assign o_flash     = q.flash;
  assign o_sched     = q.sched;
  assign o_cnt_hit   = q.chit;
  assign o_cnt_value = q.cval;
endmodule
`default_nettype wire

// ==== core/lgb_defines.svh ====
// constants for the logic gate and timing element library
`ifndef LGB_DEFINES_SVH
`define LGB_DEFINES_SVH
`define LGB_CLK_HZ       10000000
`define LGB_TB_10MS_NS   10000000
`define LGB_TB_10MS_CYC  ((`LGB_TB_10MS_NS / 1000) * (`LGB_CLK_HZ / 1000) / 1000)
`define LGB_TB_100MS_DIV 10
`define LGB_TB_1S_DIV    10
`define LGB_TB_10MS      2'h0
`define LGB_TB_100MS     2'h1
`define LGB_TB_1S        2'h2
`define LGB_TIME_W       16
`define LGB_TOD_W        11
`define LGB_CNT_W        16
`endif

// ==== core/lgb_pkg.sv ====
// shared types for the logic gate and timing element library
package lgb_pkg;
  typedef enum logic [1:0] {
    LGB_EDGE_FALL,
    LGB_EDGE_RISE,
    LGB_EDGE_BOTH
  } lgb_edge_t;
  typedef enum logic [2:0] {
    LGB_OP_AND,
    LGB_OP_OR,
    LGB_OP_NOR,
    LGB_OP_XOR,
    LGB_OP_NAND
  } lgb_op_t;
  typedef enum {
    LGB_OS_IDLE,
    LGB_OS_RUN
  } lgb_os_state_t;
endpackage

// ==== core/lgb_tick_if.sv ====
// timebase tick bundle passed from the tick divider to the elements
`timescale 1ns/1ps
`default_nettype none
interface lgb_tick_if;
  logic tick_10ms;
  logic tick_100ms;
  logic tick_1s;
  modport src (output tick_10ms, output tick_100ms, output tick_1s);
  modport dst (input tick_10ms, input tick_100ms, input tick_1s);
endinterface
`default_nettype wire

// ==== core/lgb_tick_gen.sv ====
// timebase divider producing one-cycle 10ms, 100ms and 1s ticks
`include "lgb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lgb_tick_gen #(
  parameter int unsigned BASE_CYC = `LGB_TB_10MS_CYC
) (
  input  wire logic     i_sys_clk,
  input  wire logic     i_sys_rst,
  lgb_tick_if.src       tk
);
  if (BASE_CYC < 1 || BASE_CYC > 1000000) begin : g_bad_base
    $error("bad BASE_CYC");
  end
  typedef struct packed {
    logic [19:0] div;
    logic [3:0]  d100;
    logic [3:0]  d1s;
    logic        t10;
    logic        t100;
    logic        t1s;
  } lgb_tick_st_t;
  lgb_tick_st_t q;
  lgb_tick_st_t next_q;
  always_comb begin
    next_q      = q;
    next_q.t10  = 1'b0;
    next_q.t100 = 1'b0;
    next_q.t1s  = 1'b0;
    if (q.div == 20'(BASE_CYC - 1)) begin
      next_q.div = '0;
      next_q.t10 = 1'b1;
      if (q.d100 == 4'(`LGB_TB_100MS_DIV - 1)) begin
        next_q.d100 = '0;
        next_q.t100 = 1'b1;
        if (q.d1s == 4'(`LGB_TB_1S_DIV - 1)) begin
          next_q.d1s = '0;
          next_q.t1s = 1'b1;
        end else begin
          next_q.d1s = q.d1s + 4'h1;
        end
      end else begin
        next_q.d100 = q.d100 + 4'h1;
      end
    end else begin
      next_q.div = q.div + 20'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) q <= '0;
    else           q <= next_q;
  end
  assign tk.tick_10ms  = q.t10;
  assign tk.tick_100ms = q.t100;
  assign tk.tick_1s    = q.t1s;
endmodule
`default_nettype wire

// ==== core/lgb_timer.sv ====
// one-shot and delay timer elements sharing the selected timebase
`include "lgb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lgb_timer (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_sys_rst,
  lgb_tick_if.dst                     tk,
  input  wire logic [1:0]             i_tb_sel,
  input  wire logic                   i_dly_in,
  input  wire logic [`LGB_TIME_W-1:0] i_dly_on_time,
  input  wire logic [`LGB_TIME_W-1:0] i_dly_off_time,
  input  wire logic                   i_os_in,
  input  wire logic                   i_os_retrig,
  input  wire logic [`LGB_TIME_W-1:0] i_os_time,
  output logic                        o_dly_out,
  output logic                        o_os_out
);
  typedef struct packed {
    logic [`LGB_TIME_W-1:0] dcnt;
    logic                   dout;
    logic [`LGB_TIME_W-1:0] ocnt;
    lgb_pkg::lgb_os_state_t ost;
    logic                   oin_d;
  } lgb_tmr_st_t;
  lgb_tmr_st_t q;
  lgb_tmr_st_t next_q;
  logic tick;
  always_comb begin
    case (i_tb_sel)
      `LGB_TB_10MS:  tick = tk.tick_10ms;
      `LGB_TB_100MS: tick = tk.tick_100ms;
      `LGB_TB_1S:    tick = tk.tick_1s;
      default:       tick = tk.tick_10ms;
    endcase
  end
  always_comb begin
    next_q       = q;
    next_q.oin_d = i_os_in;
    // delay: counter restarts whenever input agrees with the output
    if (i_dly_in == q.dout) begin
      next_q.dcnt = '0;
    end else if (tick) begin
      if (q.dcnt + 1'b1 >= (i_dly_in ? i_dly_on_time : i_dly_off_time)) begin
        next_q.dout = i_dly_in;
        next_q.dcnt = '0;
      end else begin
        next_q.dcnt = q.dcnt + 1'b1;
      end
    end
    // zero delay setting switches without waiting for a tick
    if (i_dly_in != q.dout &&
        (i_dly_in ? i_dly_on_time : i_dly_off_time) == '0) begin
      next_q.dout = i_dly_in;
    end
    case (q.ost)
      lgb_pkg::LGB_OS_IDLE: begin
        if (i_os_in && !q.oin_d && i_os_time != '0) begin
          next_q.ost  = lgb_pkg::LGB_OS_RUN;
          next_q.ocnt = '0;
        end
      end
      lgb_pkg::LGB_OS_RUN: begin
        // retrigger priority restarts the pulse on a new rising edge
        if (i_os_retrig && i_os_in && !q.oin_d) begin
          next_q.ocnt = '0;
        end else if (tick) begin
          if (q.ocnt + 1'b1 >= i_os_time) begin
            next_q.ost = lgb_pkg::LGB_OS_IDLE;
          end
          next_q.ocnt = q.ocnt + 1'b1;
        end
      end
      default: next_q.ost = lgb_pkg::LGB_OS_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) q <= '0;
    else           q <= next_q;
  end
  assign o_dly_out = q.dout;
  assign o_os_out  = (q.ost == lgb_pkg::LGB_OS_RUN);
endmodule
`default_nettype wire

// ==== dv/lgb_logic_lib_chk.sv ====
// assertion checker bound to the logic gate and timing element library
`timescale 1ns/1ps
`default_nettype none
module lgb_logic_lib_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic [3:0]  i_gate_in,
  input wire logic [1:0]  i_xor_in,
  input wire logic        i_latch_set,
  input wire logic        i_latch_clr,
  input wire logic        i_latch_set_wins,
  input wire logic        i_pulse_in,
  input wire logic [1:0]  i_pulse_edge,
  input wire logic        i_toggle_in,
  input wire logic        i_cnt_clr,
  input wire logic [15:0] i_cnt_set,
  input wire logic        o_and4,
  input wire logic        o_or4,
  input wire logic        o_not,
  input wire logic        o_xor2,
  input wire logic        o_nand4,
  input wire logic        o_nor4,
  input wire logic        o_latch,
  input wire logic        o_pulse,
  input wire logic        o_toggle,
  input wire logic        o_cnt_hit,
  input wire logic [15:0] o_cnt_value
);
  // syncs and output flops hold stale data for a few edges after reset
  logic [2:0] live;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      live <= 3'h0;
    end else if (live != 3'h7) begin
      live <= live + 3'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  AST_AND4: assert property (
    live == 3'h7 |-> o_and4 == &$past(i_gate_in, 3))
    else $error("and4 output wrong");
  AST_OR4: assert property (
    live == 3'h7 |-> o_or4 == |$past(i_gate_in, 3))
    else $error("or4 output wrong");
  AST_NOT: assert property (
    live == 3'h7 |-> o_not != $past(i_gate_in[0], 3))
    else $error("inverter output wrong");
  AST_XOR: assert property (
    live == 3'h7 |-> o_xor2 == ^$past(i_xor_in, 3))
    else $error("xor output wrong");
  AST_NAND: assert property (
    live == 3'h7 |-> o_nand4 == ~&$past(i_gate_in, 3))
    else $error("nand4 output wrong");
  AST_NOR: assert property (
    live == 3'h7 |-> o_nor4 == ~|$past(i_gate_in, 3))
    else $error("nor4 output wrong");
  AST_LATCH_BOTH: assert property (
    live == 3'h7 && $past(i_latch_set, 3) && $past(i_latch_clr, 3)
    |-> o_latch == $past(i_latch_set_wins, 3))
    else $error("latch priority wrong");
  AST_PULSE_RISE: assert property (
    live == 3'h7 && o_pulse && i_pulse_edge == 2'h1
    |-> $past(i_pulse_in, 3) && !$past(i_pulse_in, 4))
    else $error("pulse without rising edge");
  AST_TOGGLE: assert property (
    live == 3'h7 && o_toggle != $past(o_toggle)
    |-> $past(i_toggle_in, 3) && !$past(i_toggle_in, 4))
    else $error("toggle changed without rising edge");
  // the hit flag is held low while the clear input stands
  AST_CNT_HIT: assert property (
    live == 3'h7 |-> o_cnt_hit ==
    (!$past(i_cnt_clr, 3) && o_cnt_value >= $past(i_cnt_set)))
    else $error("counter hit flag wrong");
  AST_CNT_CLR: assert property (
    live == 3'h7 && $past(i_cnt_clr, 3)
    |-> o_cnt_value == 16'h0 && !o_cnt_hit)
    else $error("counter not cleared");
  AST_RST: assert property (
    $past(i_sys_rst) |-> !o_latch && !o_toggle && o_cnt_value == 16'h0)
    else $error("state not cleared by reset");
  COV_HIT: cover property (o_cnt_hit);
  COV_PULSE: cover property (o_pulse && i_pulse_edge == 2'h2);
  COV_BOTH: cover property (i_latch_set && i_latch_clr && i_latch_set_wins);
endmodule
bind lgb_logic_lib lgb_logic_lib_chk u_chk (
  .i_sys_clk, .i_sys_rst, .i_gate_in, .i_xor_in, .i_latch_set, .i_latch_clr,
  .i_latch_set_wins, .i_pulse_in, .i_pulse_edge, .i_toggle_in, .i_cnt_clr,
  .i_cnt_set, .o_and4, .o_or4, .o_not, .o_xor2, .o_nand4, .o_nor4, .o_latch,
  .o_pulse, .o_toggle, .o_cnt_hit, .o_cnt_value
);
`default_nettype wire

// ==== dv/lgb_logic_lib_test.sv ====
// self-checking bench for the logic gate and timing element library
`timescale 1ns/1ps
`default_nettype none
module lgb_logic_lib_test;
  localparam int BC = 10;
  logic        i_sys_clk, i_sys_rst, i_latch_set, i_latch_clr;
  logic        i_latch_set_wins, i_pulse_in, i_toggle_in, i_dly_in;
  logic        i_os_in, i_os_retrig, i_flash_en, i_cnt_in, i_cnt_clr;
  logic [3:0]  i_gate_in, i_expr_in, i_expr_neg;
  logic [2:0]  i_expr_op;
  logic [1:0]  i_xor_in, i_pulse_edge, i_tb_sel;
  logic [15:0] i_dly_on_time, i_dly_off_time, i_os_time, i_flash_time;
  logic [15:0] i_cnt_set, o_cnt_value;
  logic [10:0] i_tod, i_sched_on, i_sched_off;
  logic        o_and4, o_or4, o_not, o_xor2, o_nand4, o_nor4, o_expr;
  logic        o_latch, o_pulse, o_toggle, o_dly, o_os, o_flash, o_sched;
  logic        o_cnt_hit;
  int          num_errors, check_count, cycles;

  lgb_logic_lib #(.BASE_CYC(BC)) dut (
    .i_sys_clk, .i_sys_rst, .i_gate_in, .i_xor_in, .i_expr_in, .i_expr_op,
    .i_expr_neg, .i_latch_set, .i_latch_clr, .i_latch_set_wins, .i_pulse_in,
    .i_pulse_edge, .i_toggle_in, .i_tb_sel, .i_dly_in, .i_dly_on_time,
    .i_dly_off_time, .i_os_in, .i_os_retrig, .i_os_time, .i_flash_en,
    .i_flash_time, .i_tod, .i_sched_on, .i_sched_off, .i_cnt_in, .i_cnt_clr,
    .i_cnt_set, .o_and4, .o_or4, .o_not, .o_xor2, .o_nand4, .o_nor4, .o_expr,
    .o_latch, .o_pulse, .o_toggle, .o_dly, .o_os, .o_flash, .o_sched,
    .o_cnt_hit, .o_cnt_value
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // every drive lands 1 ns after the edge, clear of the sampling instant
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic t_gates();
    for (int v = 0; v < 16; v++) begin
      i_gate_in = v[3:0];
      i_xor_in = v[1:0];
      cyc(4);
      chk(o_and4, &v[3:0]);
      chk(o_or4, |v[3:0]);
      chk(o_not, !v[0]);
      chk(o_xor2, ^v[1:0]);
      chk(o_nand4, ~&v[3:0]);
      chk(o_nor4, ~|v[3:0]);
    end
  endtask

  task automatic t_expr();
    logic [3:0] x;
    logic       e;
    for (int op = 0; op < 6; op++) begin
      for (int v = 0; v < 16; v += 3) begin
        i_expr_op = op[2:0];
        i_expr_in = v[3:0];
        i_expr_neg = op[0] ? 4'h5 : 4'ha;
        x = v[3:0] ^ i_expr_neg;
        case (op)
          0: e = &x;
          1: e = |x;
          2: e = ~|x;
          3: e = ^x;
          4: e = ~&x;
          default: e = 1'b0;
        endcase
        cyc(4);
        chk(o_expr, e);
      end
    end
  endtask

  task automatic t_latch();
    // set, clear, wins-flag, expected output
    logic [3:0] s [5] = '{4'h9, 4'h1, 4'hc, 4'hf, 4'h6};
    foreach (s[k]) begin
      {i_latch_set, i_latch_clr, i_latch_set_wins} = s[k][3:1];
      cyc(4);
      chk(o_latch, s[k][0]);
    end
  endtask

  task automatic t_pulse();
    int n;
    for (int m = 0; m < 4; m++) begin
      i_pulse_edge = m[1:0];
      cyc(4);
      n = 0;
      for (int c = 0; c < 12; c++) begin
        i_pulse_in = c < 6;
        cyc(1);
        if (o_pulse === 1'b1) n++;
      end
      chk(n[15:0], m == 2 ? 16'h2 : m == 3 ? 16'h0 : 16'h1);
    end
  endtask

  task automatic t_toggle();
    for (int k = 1; k < 4; k++) begin
      i_toggle_in = 1'b1;
      cyc(2);
      i_toggle_in = 1'b0;
      cyc(3);
      chk(o_toggle, k[0]);
    end
  endtask

  task automatic t_dly();
    int per;
    for (int s = 0; s < 3; s++) begin
      per = s == 0 ? BC : s == 1 ? BC * 10 : BC * 100;
      i_tb_sel = s[1:0];
      i_dly_on_time = 16'h2;
      i_dly_off_time = 16'h3;
      i_dly_in = 1'b1;
      cyc(per - 2);
      chk(o_dly, 1'b0);
      cyc(per + 8);
      chk(o_dly, 1'b1);
      i_dly_in = 1'b0;
      cyc(2 * per - 2);
      chk(o_dly, 1'b1);
      cyc(per + 8);
      chk(o_dly, 1'b0);
    end
    // zero settings switch without waiting for a tick
    i_dly_on_time = 16'h0;
    i_dly_off_time = 16'h0;
    i_dly_in = 1'b1;
    cyc(5);
    chk(o_dly, 1'b1);
    i_dly_in = 1'b0;
    cyc(5);
    chk(o_dly, 1'b0);
  endtask

  task automatic t_os();
    i_tb_sel = 2'h0;
    i_os_time = 16'h4;
    for (int r = 0; r < 2; r++) begin
      i_os_retrig = r[0];
      i_os_in = 1'b1;
      cyc(2);
      i_os_in = 1'b0;
      cyc(8);
      chk(o_os, 1'b1);
      cyc(5);
      i_os_in = 1'b1;
      cyc(2);
      i_os_in = 1'b0;
      cyc(29);
      chk(o_os, r[0]);
      cyc(60);
    end
    // a zero time never fires
    i_os_time = 16'h0;
    i_os_in = 1'b1;
    cyc(2);
    i_os_in = 1'b0;
    cyc(4);
    chk(o_os, 1'b0);
  endtask

  task automatic t_flash();
    int n;
    // select code 3 falls back to the 10ms base
    i_tb_sel = 2'h3;
    i_flash_time = 16'h2;
    i_flash_en = 1'b1;
    for (n = 0; n < 60 && o_flash !== 1'b1; n++) cyc(1);
    for (n = 0; n < 60 && o_flash === 1'b1; n++) cyc(1);
    chk(n[15:0], 16'h14);
    i_flash_en = 1'b0;
    cyc(5);
    chk(o_flash, 1'b0);
  endtask

  task automatic sc(input logic [10:0] on, off, tod, input logic e);
    i_sched_on = on;
    i_sched_off = off;
    i_tod = tod;
    cyc(3);
    chk(o_sched, e);
  endtask

  task automatic t_cnt();
    for (int k = 1; k < 5; k++) begin
      i_cnt_in = 1'b1;
      cyc(2);
      i_cnt_in = 1'b0;
      cyc(3);
      chk(o_cnt_value, k[15:0]);
      chk(o_cnt_hit, k > 2);
    end
    i_cnt_clr = 1'b1;
    i_cnt_in = 1'b1;
    cyc(4);
    chk(o_cnt_value, 16'h0);
    i_cnt_in = 1'b0;
    cyc(2);
    i_cnt_clr = 1'b0;
    cyc(4);
    chk(o_cnt_value, 16'h0);
  endtask

  task automatic t_reset();
    i_latch_set = 1'b1;
    i_cnt_in = 1'b1;
    cyc(4);
    chk(o_latch, 1'b1);
    i_latch_set = 1'b0;
    i_sys_rst = 1'b1;
    cyc(3);
    i_sys_rst = 1'b0;
    i_cnt_in = 1'b0;
    cyc(1);
    chk({o_latch, o_toggle}, 16'h0);
    chk(o_cnt_value, 16'h0);
    cyc(4);
  endtask

  initial begin
    {i_latch_set, i_latch_clr, i_latch_set_wins, i_pulse_in, i_toggle_in,
     i_dly_in, i_os_in, i_os_retrig, i_flash_en, i_cnt_in, i_cnt_clr,
     i_gate_in, i_expr_in, i_expr_neg, i_expr_op, i_xor_in, i_pulse_edge,
     i_tb_sel, i_dly_on_time, i_dly_off_time, i_os_time, i_flash_time,
     i_tod, i_sched_on, i_sched_off} = '0;
    i_cnt_set = 16'h3;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    i_sys_rst = 1'b1;
    cyc(16);
    i_sys_rst = 1'b0;
    cyc(1);
    chk({o_latch, o_toggle, o_os, o_cnt_value[12:0]}, 16'h0);
    t_gates();
    t_expr();
    t_latch();
    t_pulse();
    t_toggle();
    t_dly();
    t_os();
    t_flash();
    sc(11'h00a, 11'h014, 11'h00f, 1'b1);
    sc(11'h00a, 11'h014, 11'h014, 1'b0);
    sc(11'h00a, 11'h014, 11'h009, 1'b0);
    sc(11'h3e8, 11'h064, 11'h005, 1'b1);
    sc(11'h3e8, 11'h064, 11'h1f4, 1'b0);
    sc(11'h064, 11'h064, 11'h064, 1'b0);
    t_cnt();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
